//--- hdl/crc_top.sv
// Cassette record/read control: latches, motors, FSK tones, routing, lamps, Avalon slave
`timescale 1ns/100ps
module crc_top #(
    parameter int MARK_HALF = crc_pkg::MARK_HALF_CYC,
    parameter int SPACE_HALF = crc_pkg::SPACE_HALF_CYC,
    parameter int MS_CYCLES = crc_pkg::MS_CYC
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic rec_sw_on_n_i,
    input wire logic rec_sw_off_n_i,
    input wire logic read_sw_on_n_i,
    input wire logic read_sw_off_n_i,
    input wire logic rec_sel_b_i,
    input wire logic read_sel_b_i,
    input wire logic motor_auto_i,
    input wire logic local_mode_i,
    input wire logic host_txd_i,
    input wire logic term_txd_i,
    input wire logic recorder_audio_in_a_i,
    input wire logic recorder_audio_in_b_i,
    output logic recorder_audio_out_a_o,
    output logic recorder_audio_out_b_o,
    output logic motor_a_o,
    output logic motor_b_o,
    output logic host_rxd_o,
    output logic term_rxd_o,
    output logic rec_lamp_o,
    output logic read_lamp_o,
    output logic rec_act_lamp_o,
    output logic read_act_lamp_o,
    output logic carrier_lamp_o,
    output logic bit_clk_gate_o
);
    import crc_pkg::*;

    localparam int THRESH = (MARK_HALF + SPACE_HALF) / 2;
    localparam int LOSS = LOSS_HALVES * SPACE_HALF;

    // Pin synchronisers with agreement filter
    logic [NPIN-1:0] pin_w;
    logic [NPIN-1:0] s1_q, s2_q, s3_q, flt_q, flt_d;
    assign pin_w = {recorder_audio_in_b_i, recorder_audio_in_a_i, term_txd_i, host_txd_i,
                    local_mode_i, motor_auto_i, read_sel_b_i, rec_sel_b_i,
                    read_sw_off_n_i, read_sw_on_n_i, rec_sw_off_n_i, rec_sw_on_n_i};
    for (genvar g = 0; g < NPIN; g++) begin : g_sync
        always_comb begin
            flt_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : flt_q[g];
        end
        always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                s1_q[g] <= PIN_RST[g];
                s2_q[g] <= PIN_RST[g];
                s3_q[g] <= PIN_RST[g];
                flt_q[g] <= PIN_RST[g];
            end else begin
                s1_q[g] <= pin_w[g];
                s2_q[g] <= s1_q[g];
                s3_q[g] <= s2_q[g];
                flt_q[g] <= flt_d[g];
            end
        end
    end

    logic auto_w, local_w, rec_b_w, read_b_w, ain_w;
    assign auto_w = flt_q[PIN_AUTO];
    assign local_w = flt_q[PIN_LOCAL];
    assign rec_b_w = flt_q[PIN_REC_SEL_B];
    assign read_b_w = flt_q[PIN_READ_SEL_B];
    assign ain_w = read_b_w ? flt_q[PIN_AIN_B] : flt_q[PIN_AIN_A];

    // Avalon slave: one wait cycle, then answer
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic [15:0] delay_q, delay_d;
    logic cmd_w;
    logic [3:0] cmd_bits;

    // Control state
    logic rec_lat_q, rec_lat_d, read_lat_q, read_lat_d;
    crc_car_t car_q, car_d;
    logic [15:0] dly_cnt_q, dly_cnt_d;
    logic [15:0] ms_q, ms_d;
    logic [15:0] tone_cnt_q, tone_cnt_d;
    logic tone_q, tone_d;
    logic [17:0] ivl_q, ivl_d;
    logic tbit_q, tbit_d, tval_q, tval_d, ain_prev_q, ain_prev_d;
    logic aout_a_q, aout_a_d, aout_b_q, aout_b_d, mot_a_q, mot_a_d, mot_b_q, mot_b_d;
    logic hrx_q, hrx_d, trx_q, trx_d;
    logic rlamp_q, rlamp_d, dlamp_q, dlamp_d, ract_q, ract_d, dact_q, dact_d;
    logic clamp_q, clamp_d, gate_q, gate_d;
    logic silent, tx_bit, src_bit, fwd, rec_mot, read_mot;
    logic [15:0] half;

    assign cmd_w = avs_write_i && !wait_q && (avs_address_i == ADDR_CMD);
    assign cmd_bits = avs_writedata_i[3:0];

    always_comb begin
        wait_d = 1'b1;
        rdata_d = rdata_q;
        delay_d = delay_q;
        if ((avs_read_i || avs_write_i) && wait_q) begin
            wait_d = 1'b0;
            unique case (avs_address_i)
                ADDR_DELAY: rdata_d = {16'h0000, delay_q};
                ADDR_STATUS: rdata_d = {22'h000000, gate_q, clamp_q, mot_b_q, mot_a_q,
                                        local_w, auto_w, tval_q, car_q == CAR_ON,
                                        read_lat_q, rec_lat_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
        if (avs_write_i && !wait_q && avs_address_i == ADDR_DELAY) begin
            delay_d = avs_writedata_i[15:0];
        end
    end

    always_comb begin
        // Latches: held switch overrides, else commands
        rec_lat_d = rec_lat_q;
        if (!flt_q[PIN_REC_ON_N]) begin
            rec_lat_d = 1'b1;
        end else if (!flt_q[PIN_REC_OFF_N]) begin
            rec_lat_d = 1'b0;
        end else if (cmd_w && cmd_bits[CMD_SET_REC]) begin
            rec_lat_d = 1'b1;
        end else if (cmd_w && cmd_bits[CMD_CLR_REC]) begin
            rec_lat_d = 1'b0;
        end
        read_lat_d = read_lat_q;
        if (!flt_q[PIN_READ_ON_N]) begin
            read_lat_d = 1'b1;
        end else if (!flt_q[PIN_READ_OFF_N]) begin
            read_lat_d = 1'b0;
        end else if (cmd_w && cmd_bits[CMD_SET_READ]) begin
            read_lat_d = 1'b1;
        end else if (cmd_w && cmd_bits[CMD_CLR_READ]) begin
            read_lat_d = 1'b0;
        end

        // Carrier start delay in milliseconds
        car_d = car_q;
        dly_cnt_d = dly_cnt_q;
        ms_d = ms_q;
        if (!auto_w || !rec_lat_q) begin
            car_d = CAR_OFF;
            ms_d = 16'h0000;
        end else begin
            unique case (car_q)
                CAR_OFF: begin
                    car_d = CAR_WAIT;
                    dly_cnt_d = delay_q;
                    ms_d = 16'h0000;
                end
                CAR_WAIT: begin
                    if (dly_cnt_q == 16'h0000) begin
                        car_d = CAR_ON;
                    end else if (ms_q >= 16'(MS_CYCLES - 1)) begin
                        ms_d = 16'h0000;
                        dly_cnt_d = dly_cnt_q - 16'h0001;
                    end else begin
                        ms_d = ms_q + 16'h0001;
                    end
                end
                CAR_ON: car_d = CAR_ON;
            endcase
        end

        // Record source and tone generator
        src_bit = local_w ? flt_q[PIN_TERM_TXD] : flt_q[PIN_HOST_TXD];
        if (auto_w) begin
            silent = !(rec_lat_q && car_q == CAR_ON);
            tx_bit = src_bit;
        end else begin
            silent = 1'b0;
            tx_bit = rec_lat_q ? src_bit : 1'b1;
        end
        half = tx_bit ? 16'(MARK_HALF - 1) : 16'(SPACE_HALF - 1);
        if (silent) begin
            tone_cnt_d = 16'h0000;
            tone_d = 1'b0;
        end else if (tone_cnt_q >= half) begin
            tone_cnt_d = 16'h0000;
            tone_d = !tone_q;
        end else begin
            tone_cnt_d = tone_cnt_q + 16'h0001;
            tone_d = tone_q;
        end
        aout_a_d = !rec_b_w && tone_d;
        aout_b_d = rec_b_w && tone_d;

        // Tone decoder on the selected input
        ain_prev_d = ain_w;
        ivl_d = ivl_q;
        tbit_d = tbit_q;
        tval_d = tval_q;
        if (ain_w != ain_prev_q) begin
            tbit_d = ivl_q < 18'(THRESH);
            tval_d = ivl_q < 18'(LOSS);
            ivl_d = 18'h00000;
        end else if (ivl_q >= 18'(LOSS)) begin
            tval_d = 1'b0;
            tbit_d = 1'b1;
        end else begin
            ivl_d = ivl_q + 18'h00001;
        end

        // Routing between host, terminal and tape
        fwd = read_lat_q && tval_q;
        if (local_w) begin
            hrx_d = 1'b1;
            trx_d = fwd ? tbit_q : 1'b1;
        end else begin
            hrx_d = fwd ? tbit_q : flt_q[PIN_TERM_TXD];
            trx_d = flt_q[PIN_HOST_TXD];
        end

        // Motors
        rec_mot = !auto_w || rec_lat_q;
        read_mot = !auto_w || read_lat_q;
        mot_a_d = (!rec_b_w && rec_mot) || (!read_b_w && read_mot);
        mot_b_d = (rec_b_w && rec_mot) || (read_b_w && read_mot);

        // Lamps
        rlamp_d = rec_lat_q;
        dlamp_d = read_lat_q;
        ract_d = rec_lat_q && !silent && !tx_bit;
        dact_d = read_lat_q && tval_q && !tbit_q;
        clamp_d = car_q == CAR_ON;
        gate_d = tval_q;
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
            delay_q <= DELAY_RST;
            rec_lat_q <= 1'b0;
            read_lat_q <= 1'b0;
            car_q <= CAR_OFF;
            dly_cnt_q <= 16'h0000;
            ms_q <= 16'h0000;
            tone_cnt_q <= 16'h0000;
            tone_q <= 1'b0;
            ivl_q <= 18'h00000;
            tbit_q <= 1'b1;
            tval_q <= 1'b0;
            ain_prev_q <= 1'b0;
            aout_a_q <= 1'b0;
            aout_b_q <= 1'b0;
            mot_a_q <= 1'b0;
            mot_b_q <= 1'b0;
            hrx_q <= 1'b1;
            trx_q <= 1'b1;
            rlamp_q <= 1'b0;
            dlamp_q <= 1'b0;
            ract_q <= 1'b0;
            dact_q <= 1'b0;
            clamp_q <= 1'b0;
            gate_q <= 1'b0;
        end else begin
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            delay_q <= delay_d;
            rec_lat_q <= rec_lat_d;
            read_lat_q <= read_lat_d;
            car_q <= car_d;
            dly_cnt_q <= dly_cnt_d;
            ms_q <= ms_d;
            tone_cnt_q <= tone_cnt_d;
            tone_q <= tone_d;
            ivl_q <= ivl_d;
            tbit_q <= tbit_d;
            tval_q <= tval_d;
            ain_prev_q <= ain_prev_d;
            aout_a_q <= aout_a_d;
            aout_b_q <= aout_b_d;
            mot_a_q <= mot_a_d;
            mot_b_q <= mot_b_d;
            hrx_q <= hrx_d;
            trx_q <= trx_d;
            rlamp_q <= rlamp_d;
            dlamp_q <= dlamp_d;
            ract_q <= ract_d;
            dact_q <= dact_d;
            clamp_q <= clamp_d;
            gate_q <= gate_d;
        end
    end

    assign avs_waitrequest_o = wait_q;
    assign avs_readdata_o = rdata_q;
    assign recorder_audio_out_a_o = aout_a_q;
    assign recorder_audio_out_b_o = aout_b_q;
    assign motor_a_o = mot_a_q;
    assign motor_b_o = mot_b_q;
    assign host_rxd_o = hrx_q;
    assign term_rxd_o = trx_q;
    assign rec_lamp_o = rlamp_q;
    assign read_lamp_o = dlamp_q;
    assign rec_act_lamp_o = ract_q;
    assign read_act_lamp_o = dact_q;
    assign carrier_lamp_o = clamp_q;
    assign bit_clk_gate_o = gate_q;
    // Checks
    property p_manual_motor;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        !auto_w |=> (($past(rec_b_w) ? mot_b_q : mot_a_q) &&
                     ($past(read_b_w) ? mot_b_q : mot_a_q));
    endproperty
    a_manual_motor: assert property (p_manual_motor) else $error("manual motor off");
    property p_auto_idle_motor;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (auto_w && !rec_lat_q && !read_lat_q) |=> (!mot_a_q && !mot_b_q);
    endproperty
    a_auto_idle_motor: assert property (p_auto_idle_motor) else $error("idle motor on");
    property p_auto_silent;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (auto_w && !rec_lat_q) |=> (!aout_a_q && !aout_b_q);
    endproperty
    a_auto_silent: assert property (p_auto_silent) else $error("audio while clear");
    property p_car_delay;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (auto_w && car_q == CAR_OFF && rec_lat_q) |=> (car_q == CAR_WAIT) ##1 !clamp_q;
    endproperty
    a_car_delay: assert property (p_car_delay) else $error("carrier not delayed");
    property p_rec_force;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        !flt_q[PIN_REC_ON_N] |=> rec_lat_q ##1 rlamp_q;
    endproperty
    a_rec_force: assert property (p_rec_force) else $error("record latch not forced");
    property p_lamp;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (rlamp_q == $past(rec_lat_q)) && (dlamp_q == $past(read_lat_q));
    endproperty
    a_lamp: assert property (p_lamp) else $error("latch lamp wrong");
    property p_rec_act;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        ract_q |-> $past(rec_lat_q);
    endproperty
    a_rec_act: assert property (p_rec_act) else $error("record lamp without latch");
    property p_read_act;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        dact_q |-> ($past(read_lat_q) && $past(tval_q) && !$past(tbit_q));
    endproperty
    a_read_act: assert property (p_read_act) else $error("read lamp wrong");
    property p_local;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        local_w |=> hrx_q;
    endproperty
    a_local: assert property (p_local) else $error("host fed in local");
    property p_pass;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (!local_w && !read_lat_q) |=> (hrx_q == $past(flt_q[PIN_TERM_TXD]));
    endproperty
    a_pass: assert property (p_pass) else $error("serial not passed");
    property p_bus;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        ((avs_read_i || avs_write_i) && wait_q) |=> !wait_q ##1 wait_q;
    endproperty
    a_bus: assert property (p_bus) else $error("waitrequest timing");
endmodule : crc_top

//--- hdl/crc_pkg.sv
// Package: constants, register map and types for the cassette record/read control block
package crc_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int MARK_HZ = 2400;
    localparam int SPACE_HZ = 1200;
    localparam int MS_PER_S = 1000;
    localparam int LOSS_HALVES = 4;
    localparam int MARK_HALF_CYC = CLK_HZ / (2 * MARK_HZ);
    localparam int SPACE_HALF_CYC = CLK_HZ / (2 * SPACE_HZ);
    localparam int MS_CYC = CLK_HZ / MS_PER_S;

    localparam logic [3:0] ADDR_CMD = 4'h0;
    localparam logic [3:0] ADDR_DELAY = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;

    localparam int CMD_SET_REC = 0;
    localparam int CMD_CLR_REC = 1;
    localparam int CMD_SET_READ = 2;
    localparam int CMD_CLR_READ = 3;

    localparam logic [15:0] DELAY_RST = 16'h03E8;

    localparam int NPIN = 12;
    localparam int PIN_REC_ON_N = 0;
    localparam int PIN_REC_OFF_N = 1;
    localparam int PIN_READ_ON_N = 2;
    localparam int PIN_READ_OFF_N = 3;
    localparam int PIN_REC_SEL_B = 4;
    localparam int PIN_READ_SEL_B = 5;
    localparam int PIN_AUTO = 6;
    localparam int PIN_LOCAL = 7;
    localparam int PIN_HOST_TXD = 8;
    localparam int PIN_TERM_TXD = 9;
    localparam int PIN_AIN_A = 10;
    localparam int PIN_AIN_B = 11;
    localparam logic [NPIN-1:0] PIN_RST = 12'h30F;

    typedef enum logic [1:0] {CAR_OFF, CAR_WAIT, CAR_ON} crc_car_t;
endpackage : crc_pkg

//--- test/crc_tape_model.sv
// Tape recorder model that plays FSK tones back into the interface
`timescale 1ns/100ps
module crc_tape_model #(
    parameter int MH = 4,
    parameter int SH = 8
) (
    input wire logic clk_i,
    input wire logic play_i,
    input wire logic bit_i,
    output logic audio_o
);
    int cnt;
    initial begin
        audio_o = 1'b0;
        cnt = 0;
    end
    // Blank tape holds its level, so no tone edges reach the detector
    always @(posedge clk_i) begin
        if (play_i) begin
            cnt <= cnt + 1;
            if (cnt >= (bit_i ? MH : SH) - 1) begin
                audio_o <= ~audio_o;
                cnt <= 0;
            end
        end else begin
            cnt <= 0;
        end
    end
endmodule : crc_tape_model

//--- test/crc_top_test.sv
// Self-checking testbench for the cassette record/read control block
`timescale 1ns/100ps
module crc_top_test;
    import crc_pkg::*;
    localparam int MH = 4;
    localparam int SH = 8;
    localparam int NONE = 40;
    logic sys_clk_i, reset_n_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic [3:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o;
    logic rec_sw_on_n_i, rec_sw_off_n_i, read_sw_on_n_i, read_sw_off_n_i;
    logic rec_sel_b_i, read_sel_b_i, motor_auto_i, local_mode_i, host_txd_i, term_txd_i;
    logic recorder_audio_in_a_i, recorder_audio_in_b_i, recorder_audio_out_a_o;
    logic recorder_audio_out_b_o, motor_a_o, motor_b_o, host_rxd_o, term_rxd_o;
    logic rec_lamp_o, read_lamp_o, rec_act_lamp_o, read_act_lamp_o;
    logic carrier_lamp_o, bit_clk_gate_o, play, tbit, hb;
    logic [31:0] exp_q[$];
    int fail_count, total_checks, cyc, seed, n, i;

    crc_top #(.MARK_HALF(MH), .SPACE_HALF(SH), .MS_CYCLES(10)) dut (
        .sys_clk_i, .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .rec_sw_on_n_i,
        .rec_sw_off_n_i, .read_sw_on_n_i, .read_sw_off_n_i, .rec_sel_b_i, .read_sel_b_i,
        .motor_auto_i, .local_mode_i, .host_txd_i, .term_txd_i, .recorder_audio_in_a_i,
        .recorder_audio_in_b_i, .recorder_audio_out_a_o, .recorder_audio_out_b_o,
        .motor_a_o, .motor_b_o, .host_rxd_o, .term_rxd_o, .rec_lamp_o, .read_lamp_o,
        .rec_act_lamp_o, .read_act_lamp_o, .carrier_lamp_o, .bit_clk_gate_o
    );
    crc_tape_model #(.MH(MH), .SH(SH)) tape (
        .clk_i(sys_clk_i), .play_i(play), .bit_i(tbit), .audio_o(recorder_audio_in_a_i)
    );

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic results;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    task automatic wt(input int k);
        repeat (k) @(posedge sys_clk_i);
    endtask : wt

    // Avalon access: held until waitrequest is seen low, reads note the expected word
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [31:0] e);
        if (!w) begin
            exp_q.push_back(e);
        end
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        do begin
            @(posedge sys_clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask : bus

    task automatic cmd(input int c);
        bus(1'b1, ADDR_CMD, 32'h1 << c, 32'h0);
        wt(3);
    endtask : cmd

    // Half period of the tone on one record output; NONE when it stays still
    task automatic half(input logic b, output int m);
        logic p;
        int k;
        for (k = 0; k < 2; k++) begin
            p = b ? recorder_audio_out_b_o : recorder_audio_out_a_o;
            m = 0;
            while ((b ? recorder_audio_out_b_o : recorder_audio_out_a_o) === p && m < NONE) begin
                @(posedge sys_clk_i);
                m++;
            end
        end
    endtask : half

    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc > 30000) begin
            fail_count++;
            results();
        end else if (avs_read_i && avs_waitrequest_o === 1'b0) begin
            check("readdata", avs_readdata_o, exp_q.pop_front());
        end
    end

    initial begin
        seed = 99;
        {fail_count, total_checks, cyc} = '0;
        {reset_n_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
        {rec_sw_on_n_i, rec_sw_off_n_i, read_sw_on_n_i, read_sw_off_n_i} = 4'hF;
        {rec_sel_b_i, read_sel_b_i, motor_auto_i, local_mode_i, play} = '0;
        {host_txd_i, term_txd_i, tbit, recorder_audio_in_b_i} = 4'hE;
        wt(3);
        reset_n_i <= 1'b1;
        wt(8);
        bus(1'b0, ADDR_DELAY, 32'h0, 32'h0000_03E8);
        bus(1'b0, 4'hC, 32'h0, 32'h0);
        // Manual mode: motors on for both selected recorders, mark carrier only on the selected recorder
        read_sel_b_i <= 1'b1;
        wt(8);
        check("motor_a", motor_a_o, 1);
        check("motor_b", motor_b_o, 1);
        read_sel_b_i <= 1'b0;
        for (i = 1; i >= 0; i--) begin
            rec_sel_b_i <= i[0];
            wt(10);
            half(i[0], n);
            check("mark half", n, MH);
            half(!i[0], n);
            check("unselected out", n, NONE);
        end
        cmd(CMD_SET_REC);
        check("rec lamp", rec_lamp_o, 1);
        for (i = 0; i < 5; i++) begin
            hb = 1'($random(seed));
            host_txd_i <= hb;
            wt(12);
            half(1'b0, n);
            check("copied half", n, hb ? MH : SH);
            check("rec act lamp", rec_act_lamp_o, !hb);
        end
        host_txd_i <= 1'b0;
        cmd(CMD_CLR_REC);
        wt(8);
        half(1'b0, n);
        check("after clear", n, MH);
        check("rec act lamp", rec_act_lamp_o, 0);
        check("rec lamp", rec_lamp_o, 0);
        host_txd_i <= 1'b1;
        // Held switches override commands; a flick updates the latch
        rec_sw_off_n_i <= 1'b0;
        wt(8);
        cmd(CMD_SET_REC);
        check("rec held off", rec_lamp_o, 0);
        rec_sw_off_n_i <= 1'b1;
        rec_sw_on_n_i <= 1'b0;
        wt(8);
        rec_sw_on_n_i <= 1'b1;
        wt(8);
        check("rec flick on", rec_lamp_o, 1);
        cmd(CMD_CLR_REC);
        check("rec cleared", rec_lamp_o, 0);
        read_sw_on_n_i <= 1'b0;
        wt(8);
        cmd(CMD_CLR_READ);
        check("read held on", read_lamp_o, 1);
        read_sw_on_n_i <= 1'b1;
        wt(8);
        cmd(CMD_CLR_READ);
        check("read cleared", read_lamp_o, 0);
        // Read path and routing in remote and local mode, local recording
        tbit <= 1'b0;
        play <= 1'b1;
        wt(80);
        check("tape ignored", host_rxd_o, 1);
        check("read act lamp", read_act_lamp_o, 0);
        term_txd_i <= 1'b0;
        wt(8);
        check("term to host", host_rxd_o, 0);
        term_txd_i <= 1'b1;
        cmd(CMD_SET_READ);
        wt(40);
        check("tape space", host_rxd_o, 0);
        check("read act lamp", read_act_lamp_o, 1);
        check("clock gate", bit_clk_gate_o, 1);
        tbit <= 1'b1;
        wt(60);
        check("tape mark", host_rxd_o, 1);
        check("read act lamp", read_act_lamp_o, 0);
        tbit <= 1'b0;
        host_txd_i <= 1'b0;
        wt(60);
        check("host to term", term_rxd_o, 0);
        host_txd_i <= 1'b1;
        read_sel_b_i <= 1'b1;
        wt(80);
        check("read sel b", host_rxd_o, 1);
        read_sel_b_i <= 1'b0;
        local_mode_i <= 1'b1;
        wt(60);
        check("local host", host_rxd_o, 1);
        check("local term", term_rxd_o, 0);
        cmd(CMD_SET_REC);
        term_txd_i <= 1'b0;
        wt(12);
        half(1'b0, n);
        check("local record", n, SH);
        cmd(CMD_CLR_REC);
        term_txd_i <= 1'b1;
        local_mode_i <= 1'b0;
        play <= 1'b0;
        wt(80);
        check("tones lost", bit_clk_gate_o, 0);
        check("tones lost rxd", host_rxd_o, 1);
        cmd(CMD_CLR_READ);
        // Automatic motor mode
        motor_auto_i <= 1'b1;
        host_txd_i <= 1'b0;
        wt(10);
        check("auto motor_a", motor_a_o, 0);
        check("auto motor_b", motor_b_o, 0);
        half(1'b0, n);
        check("auto silent", n, NONE);
        host_txd_i <= 1'b1;
        bus(1'b0, ADDR_STATUS, 32'h0, 32'h0000_0010);
        bus(1'b1, ADDR_DELAY, 32'h3, 32'h0);
        bus(1'b0, ADDR_DELAY, 32'h0, 32'h3);
        cmd(CMD_SET_REC);
        check("rec motor", motor_a_o, 1);
        wt(18);
        check("carrier held", recorder_audio_out_a_o, 0);
        check("carrier lamp", carrier_lamp_o, 0);
        wt(30);
        check("carrier lamp", carrier_lamp_o, 1);
        half(1'b0, n);
        check("auto carrier", n, MH);
        cmd(CMD_CLR_REC);
        check("rec motor off", motor_a_o, 0);
        half(1'b0, n);
        check("audio stopped", n, NONE);
        wt(20);
        cmd(CMD_SET_READ);
        check("read motor", motor_a_o, 1);
        wt(40);
        check("no tones", host_rxd_o, 1);
        play <= 1'b1;
        wt(60);
        check("tones found", host_rxd_o, 0);
        play <= 1'b0;
        cmd(CMD_CLR_READ);
        check("read motor off", motor_a_o, 0);
        results();
    end
endmodule : crc_top_test
